// File: design/mpo_sequencer.sv
// power on, power off and unconditional restart sequencer of the modem
// assumes pads arrive asynchronously; open-drain pads are resolved outside
`timescale 1ns/1ns
module mpo_sequencer
    import mpo_pkg::*;
#(
    parameter int unsigned PRESS_ON_N  = mpo_pkg::PRESS_ON_CYC,
    parameter int unsigned PRESS_OFF_N = mpo_pkg::PRESS_OFF_CYC,
    parameter int unsigned RESTART_N   = mpo_pkg::RESTART_CYC,
    parameter int unsigned READY_N     = mpo_pkg::READY_CYC
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       power_key_n_in,
    output logic            power_key_pull_oe,
    input  wire logic       restart_n_in,
    output logic            restart_pull_oe,
    input  wire logic       battery_supply,
    input  wire logic       charger_in,
    input  wire logic       rts_in,
    input  wire logic       sw_off_cmd,
    input  wire logic       detach_done,
    input  wire logic       wake_event,
    input  wire logic       level_wr,
    input  wire logic [1:0] level_wdata,
    output logic [1:0]      function_level,
    output logic            cmd_accept,
    output logic            detach_req,
    output logic            power_good_out,
    output logic            module_ready
);
    import mpo_pkg::*;

    // two-stage synchronisers; first stage feeds only the second
    logic [4:0] s1_q, s2_q;
    logic       key_n, rst_line_n, batt, chg, rts;
    // reset to each pad's idle level: keys high, supplies and rts low, so no false edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 5'h18;
            s2_q <= 5'h18;
        end else begin
            s1_q <= {power_key_n_in, restart_n_in, battery_supply, charger_in, rts_in};
            s2_q <= s1_q;
        end
    end
    assign key_n      = s2_q[4];
    assign rst_line_n = s2_q[3];
    assign batt       = s2_q[2];
    assign chg        = s2_q[1];
    assign rts        = s2_q[0];

    mpo_timer_if key_tmr ();
    mpo_timer_if rst_tmr ();
    assign key_tmr.level = key_n;
    assign rst_tmr.level = rst_line_n;

    mpo_press_timer u_key_tmr (
        .clock (clock),
        .rst_n (rst_n),
        .tmr   (key_tmr)
    );
    mpo_press_timer u_rst_tmr (
        .clock (clock),
        .rst_n (rst_n),
        .tmr   (rst_tmr)
    );

    mpo_state_type    st_q, st_d;
    logic             key_n_q, key_n_d, rst_n_q, rst_n_d, chg_q, chg_d, rts_q, rts_d;
    logic [CNT_W-1:0] rdy_q, rdy_d;
    logic [1:0]       lvl_q, lvl_d;
    logic             pg_q, pg_d, ready_q, ready_d, det_q, det_d, acc_q, acc_d;
    logic             key_rel, rst_rel, chg_rise, rts_rise;

    assign key_rel  = key_n && !key_n_q;
    assign rst_rel  = rst_line_n && !rst_n_q;
    assign chg_rise = chg && !chg_q;
    assign rts_rise = rts && !rts_q;

    always_comb begin
        st_d    = st_q;
        key_n_d = key_n;
        rst_n_d = rst_line_n;
        chg_d   = chg;
        rts_d   = rts;
        lvl_d   = lvl_q;
        pg_d    = pg_q;
        rdy_d   = rdy_q;
        ready_d = ready_q;
        det_d   = 1'b0;
        acc_d   = 1'b0;
        unique case (st_q)
            ST_OFF: begin
                pg_d = 1'b0;
                if (key_rel && key_tmr.held >= PRESS_ON_N) begin
                    st_d = ST_BOOT;
                end else if (chg_rise && batt) begin
                    st_d = ST_BOOT;
                end
            end
            ST_BOOT: begin
                pg_d  = 1'b1;
                rdy_d = '0;
                lvl_d = LEVEL_FULL;
                st_d  = ST_ON;
            end
            ST_ON: begin
                if (rdy_q < READY_N) begin
                    rdy_d = rdy_q + 32'h1;
                end else begin
                    ready_d = 1'b1;
                end
                if (level_wr && lvl_q != LEVEL_SLEEP) begin
                    lvl_d = level_wdata;
                end
                acc_d = level_wr && lvl_q != LEVEL_SLEEP;
                if (lvl_q == LEVEL_SLEEP && (wake_event || rts_rise)) begin
                    lvl_d = LEVEL_FULL;
                end
                if ((sw_off_cmd && lvl_q != LEVEL_SLEEP)
                    || (key_rel && key_tmr.held >= PRESS_OFF_N)) begin
                    st_d  = ST_DETACH;
                    det_d = 1'b1;
                end
            end
            ST_DETACH: begin
                det_d = !detach_done;
                if (detach_done) begin
                    st_d    = ST_OFF;
                    pg_d    = 1'b0;
                    ready_d = 1'b0;
                    lvl_d   = LEVEL_RESET;
                end
            end
            ST_RESTART: begin
                pg_d    = 1'b0;
                ready_d = 1'b0;
                lvl_d   = LEVEL_RESET;
                if (rst_rel) begin
                    st_d = ST_BOOT;
                end
            end
            default: st_d = ST_OFF;
        endcase
        if (!rst_line_n && rst_tmr.held >= RESTART_N && st_q != ST_RESTART) begin
            st_d = ST_RESTART;
            det_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= ST_OFF;
            key_n_q <= 1'b1;
            rst_n_q <= 1'b1;
            chg_q   <= 1'b0;
            rts_q   <= 1'b0;
            lvl_q   <= LEVEL_RESET;
            pg_q    <= 1'b0;
            rdy_q   <= '0;
            ready_q <= 1'b0;
            det_q   <= 1'b0;
            acc_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            key_n_q <= key_n_d;
            rst_n_q <= rst_n_d;
            chg_q   <= chg_d;
            rts_q   <= rts_d;
            lvl_q   <= lvl_d;
            pg_q    <= pg_d;
            rdy_q   <= rdy_d;
            ready_q <= ready_d;
            det_q   <= det_d;
            acc_q   <= acc_d;
        end
    end

    // internal pull-ups stay enabled so unconnected pads idle high
    assign power_key_pull_oe = 1'b1;
    assign restart_pull_oe   = 1'b1;
    assign power_good_out    = pg_q;
    assign module_ready      = ready_q;
    assign detach_req        = det_q;
    assign function_level    = lvl_q;
    assign cmd_accept        = acc_q;

    off_detach_a: assert property (@(posedge clock) disable iff (!rst_n)
        (st_q == ST_ON && st_d == ST_DETACH) |=> detach_req)
        else $error("no detach request at shutdown");
    pg_low_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        (st_q == ST_DETACH && detach_done) |=> !power_good_out)
        else $error("power good still high after off");
    boot_pg_a: assert property (@(posedge clock) disable iff (!rst_n)
        (st_q == ST_BOOT) |=> power_good_out)
        else $error("power good not raised on boot");
    no_off_held_a: assert property (@(posedge clock) disable iff (!rst_n)
        (st_q == ST_ON && !key_n && !sw_off_cmd) |=> st_q != ST_DETACH)
        else $error("shutdown while key still held");
    charge_on_a: assert property (@(posedge clock) disable iff (!rst_n)
        (st_q == ST_OFF && chg_rise && batt && rst_line_n) |=> ##1 power_good_out)
        else $error("charger start did not power on");
    sleep_refuse_a: assert property (@(posedge clock) disable iff (!rst_n)
        (lvl_q == LEVEL_SLEEP && level_wr) |=> !cmd_accept)
        else $error("command accepted in sleep level");
    restart_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!rst_line_n && rst_tmr.held >= RESTART_N) |=> st_q == ST_RESTART)
        else $error("restart press ignored");
    pulls_a: assert property (@(posedge clock) disable iff (!rst_n)
        power_key_pull_oe && restart_pull_oe)
        else $error("pull-up dropped");

    // key power-on walk: one boot cycle, then power good at full level
    sequence boot_walk_s;
        (st_q == ST_BOOT) ##1 (power_good_out && function_level == LEVEL_FULL);
    endsequence
    key_on_a: assert property (@(posedge clock) disable iff (!rst_n)
        (st_q == ST_OFF && key_rel && key_tmr.held >= PRESS_ON_N && rst_line_n)
        |=> boot_walk_s)
        else $error("key press did not power on");
endmodule // mpo_sequencer

// File: design/mpo_pkg.sv
// package for the module power on/off/restart sequencer
// assumes a single 250 MHz clock domain
package mpo_pkg;
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned PRESS_ON_MS     = 1000;
    localparam int unsigned PRESS_OFF_MS    = 2000;
    localparam int unsigned RESTART_MS      = 200;
    localparam int unsigned READY_MS        = 900;
    // least times round up: ms * 1000 us * MHz cycles
    localparam int unsigned PRESS_ON_CYC    = PRESS_ON_MS * 1000 * CLK_MHZ;
    localparam int unsigned PRESS_OFF_CYC   = PRESS_OFF_MS * 1000 * CLK_MHZ;
    localparam int unsigned RESTART_CYC     = RESTART_MS * 1000 * CLK_MHZ;
    localparam int unsigned READY_CYC       = READY_MS * 1000 * CLK_MHZ;
    localparam int unsigned CNT_W           = 32;
    localparam logic [1:0]  LEVEL_FULL      = 2'h1;
    localparam logic [1:0]  LEVEL_SLEEP     = 2'h0;
    localparam logic [1:0]  LEVEL_SAVE      = 2'h2;
    localparam logic [1:0]  LEVEL_RESET     = 2'h0;

    typedef enum logic [2:0] {
        ST_OFF      = 3'h0,
        ST_BOOT     = 3'h1,
        ST_ON       = 3'h2,
        ST_DETACH   = 3'h3,
        ST_RESTART  = 3'h4
    } mpo_state_type;
endpackage

// File: design/mpo_timer_if.sv
// interface between the sequencer and its press timer
// assumes both ends on the same clock
`timescale 1ns/1ns
interface mpo_timer_if;
    logic        level;
    logic [31:0] held;
    modport owner (output held, input level);
    modport user  (output level, input held);
endinterface

// File: design/mpo_press_timer.sv
// counts how long an active-low line has been held low
// assumes the line is already synchronised
`timescale 1ns/1ns
module mpo_press_timer (
    input  wire logic   clock,
    input  wire logic   rst_n,
    mpo_timer_if.owner  tmr
);
    import mpo_pkg::*;
    logic [CNT_W-1:0] held_q, held_d;

    always_comb begin
        held_d = held_q;
        if (tmr.level) begin
            held_d = '0;
        end else if (held_q != {CNT_W{1'b1}}) begin
            held_d = held_q + 32'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            held_q <= '0;
        end else begin
            held_q <= held_d;
        end
    end

    assign tmr.held = held_q;
endmodule // mpo_press_timer

// File: testbench/mpo_host_model.sv
// host side of the power key and restart pads: open-collector sinks only
// assumes the sequencer's pull enables give the idle high level
`timescale 1ns/1ns
module mpo_host_model (
    input  wire logic clock,
    input  wire logic key_pull_oe,
    input  wire logic rst_pull_oe,
    output logic      key_pad_n,
    output logic      restart_pad_n
);
    logic key_sink_q = 1'b0;
    logic rst_sink_q = 1'b0;
    // never driven high: without the pull-up the line floats
    assign key_pad_n     = key_sink_q ? 1'b0 : (key_pull_oe ? 1'b1 : 1'bz);
    assign restart_pad_n = rst_sink_q ? 1'b0 : (rst_pull_oe ? 1'b1 : 1'bz);

    task automatic press_key(input int unsigned n);
        @(posedge clock);
        key_sink_q <= 1'b1;
        repeat (n) @(posedge clock);
        key_sink_q <= 1'b0;
    endtask

    task automatic press_restart(input int unsigned n);
        @(posedge clock);
        rst_sink_q <= 1'b1;
        repeat (n) @(posedge clock);
        rst_sink_q <= 1'b0;
    endtask
endmodule // mpo_host_model

// File: testbench/testbench.sv
// self-checking bench of the power on/off/restart sequencer
// assumes short press and ready counts set by parameter
`timescale 1ns/1ns
module testbench;
    import mpo_pkg::*;
    localparam int unsigned ON_N = 20, OFF_N = 40, RS_N = 10, RDY_N = 30;
    logic       clock = 1'b0, rst_n = 1'b0;
    logic       battery_supply = 1'b0, charger_in = 1'b0, rts_in = 1'b0;
    logic       sw_off_cmd = 1'b0, detach_done = 1'b0, wake_event = 1'b0;
    logic       level_wr = 1'b0, hit;
    logic [1:0] level_wdata = 2'h0, function_level;
    logic       key_n, restart_n, key_oe, rst_oe, cmd_accept, detach_req;
    logic       power_good_out, module_ready;
    int         miscompares = 0, compares = 0;

    mpo_sequencer #(.PRESS_ON_N(ON_N), .PRESS_OFF_N(OFF_N), .RESTART_N(RS_N),
        .READY_N(RDY_N)) mpo_sequencer_inst (.clock(clock), .rst_n(rst_n),
        .power_key_n_in(key_n), .power_key_pull_oe(key_oe), .restart_n_in(restart_n),
        .restart_pull_oe(rst_oe), .battery_supply(battery_supply),
        .charger_in(charger_in), .rts_in(rts_in), .sw_off_cmd(sw_off_cmd),
        .detach_done(detach_done), .wake_event(wake_event), .level_wr(level_wr),
        .level_wdata(level_wdata), .function_level(function_level),
        .cmd_accept(cmd_accept), .detach_req(detach_req),
        .power_good_out(power_good_out), .module_ready(module_ready));
    mpo_host_model mpo_host_model_inst (.clock(clock), .key_pull_oe(key_oe),
        .rst_pull_oe(rst_oe), .key_pad_n(key_n), .restart_pad_n(restart_n));

    initial begin
        forever #2 clock = ~clock;
    end

    task automatic end_of_test();
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // sel 0 power good, 1 detach request, 2 ready, 3 accept; hit tells if seen in time
    task automatic wait_on(input int sel, input logic v, input int bound);
        logic s;
        hit = 1'b0;
        repeat (bound) begin
            #1;
            case (sel)
                0: s = power_good_out;
                1: s = detach_req;
                2: s = module_ready;
                default: s = cmd_accept;
            endcase
            if (s === v) begin
                hit = 1'b1;
                return;
            end
            @(posedge clock);
        end
    endtask

    // sel 0 rts_in, 1 wake_event, 2 sw_off_cmd, 3 detach_done; high for one cycle
    task automatic pulse(input int sel);
        @(posedge clock);
        case (sel)
            0: rts_in <= 1'b1;
            1: wake_event <= 1'b1;
            2: sw_off_cmd <= 1'b1;
            default: detach_done <= 1'b1;
        endcase
        @(posedge clock);
        rts_in      <= 1'b0;
        wake_event  <= 1'b0;
        sw_off_cmd  <= 1'b0;
        detach_done <= 1'b0;
    endtask

    task automatic write_level(input logic [1:0] v, input logic expect_ok);
        @(posedge clock);
        level_wr    <= 1'b1;
        level_wdata <= v;
        @(posedge clock);
        level_wr <= 1'b0;
        wait_on(3, 1'b1, 4);
        check("cmd_accept", expect_ok, hit);
    endtask

    task automatic t_reset();
        check("pull enables", 2'h3, {key_oe, rst_oe});
        check("power_good_out", 2'h0, power_good_out);
    endtask

    task automatic t_power_on();
        mpo_host_model_inst.press_key(ON_N - 5);
        wait_on(0, 1'b1, 12);
        check("short press", 1'b0, hit);
        mpo_host_model_inst.press_key(ON_N + 2);
        wait_on(0, 1'b1, 10);
        check("power_good_out", 1'b1, hit);
        check("function_level", LEVEL_FULL, function_level);
        wait_on(2, 1'b1, RDY_N - 2);
        check("early ready", 1'b0, hit);
        wait_on(2, 1'b1, 6);
        check("module_ready", 1'b1, hit);
    endtask

    task automatic t_levels();
        write_level(LEVEL_SAVE, 1'b1);
        check("function_level", LEVEL_SAVE, function_level);
        write_level(LEVEL_SLEEP, 1'b1);
        write_level(LEVEL_FULL, 1'b0);
        check("function_level", LEVEL_SLEEP, function_level);
        pulse(2);
        repeat (2) @(posedge clock);
        check("sleep off refused", 2'h2, {power_good_out, detach_req});
        pulse(0);
        repeat (5) @(posedge clock);
        check("rts wake", 1'b1, function_level !== LEVEL_SLEEP);
        write_level(LEVEL_SLEEP, 1'b1);
        pulse(1);
        repeat (3) @(posedge clock);
        check("call wake", 1'b1, function_level !== LEVEL_SLEEP);
    endtask

    task automatic shut_down();
        wait_on(1, 1'b1, 12);
        check("detach_req", 1'b1, hit);
        pulse(3);
        wait_on(0, 1'b0, 4);
        check("power off", 1'b1, hit);
        check("module_ready", 1'b0, module_ready);
    endtask

    task automatic t_key_off();
        fork
            mpo_host_model_inst.press_key(OFF_N + 2);
        join_none
        repeat (OFF_N) @(posedge clock);
        check("held key", 2'h2, {power_good_out, detach_req});
        shut_down();
    endtask

    task automatic t_charger_sw_off();
        @(posedge clock);
        battery_supply <= 1'b1;
        charger_in     <= 1'b1;
        wait_on(0, 1'b1, 10);
        check("charger start", 1'b1, hit);
        pulse(2);
        shut_down();
        @(posedge clock);
        charger_in <= 1'b0;
    endtask

    task automatic t_restart();
        check("power state", 1'b0, power_good_out);
        mpo_host_model_inst.press_key(ON_N + 2);
        wait_on(0, 1'b1, 10);
        check("power_good_out", 1'b1, hit);
        fork
            mpo_host_model_inst.press_restart(RS_N + 2);
        join_none
        wait_on(0, 1'b0, RS_N + 10);
        check("restart off", 2'h1, {detach_req, hit});
        wait_on(0, 1'b1, 20);
        check("reboot", 1'b1, hit);
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset();
        t_power_on();
        t_levels();
        t_key_off();
        t_charger_sw_off();
        t_restart();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_of_test();
    end
endmodule // testbench
